/* File: core/pmits_dec_if.sv */
// pmits_dec_if: address and range config going to the decoder, hits back.
// assumes both ends sit on clk_sys; the decode itself is combinational.
`timescale 1ns/1ps
interface pmits_dec_if;
    logic [15:0] addr;
    logic [1:0]  ser_assign;
    logic        pri_sel;
    logic        sec_sel;
    logic        hit_parser;
    logic        hit_floppy;
    logic        hit_pri_hd;
    logic        hit_sec_hd;
    modport dec  (input addr, ser_assign, pri_sel, sec_sel,
                  output hit_parser, hit_floppy, hit_pri_hd, hit_sec_hd);
    modport user (output addr, ser_assign, pri_sel, sec_sel,
                  input hit_parser, hit_floppy, hit_pri_hd, hit_sec_hd);
endinterface

/* File: core/pmits_decode.sv */
// pmits_decode: legacy i/o range decoder for the trap and idle logic.
// assumes a stable 16-bit address; outputs are pure combinational hits.
`timescale 1ns/1ps
module pmits_decode
    import pmits_pkg::*;
(
    pmits_dec_if.dec dif
);
    logic a_com1;
    logic a_com2;

    // first and second serial ranges, each droppable by the assignment field
    always_comb
    begin
        a_com1 = in_range(dif.addr, COM1_LO, COM1_HI) && (dif.ser_assign != SER_DROP_FIRST);
        a_com2 = in_range(dif.addr, COM2_LO, COM2_HI) && (dif.ser_assign != SER_DROP_SECOND);
        dif.hit_parser = in_range(dif.addr, LPT1_LO, LPT1_HI) || in_range(dif.addr, LPT2_LO, LPT2_HI)
                       || in_range(dif.addr, COM3_LO, COM3_HI) || in_range(dif.addr, COM4_LO, COM4_HI)
                       || a_com1 || a_com2;
        dif.hit_floppy = in_range(dif.addr, FDP_LO, FDP_HI) || (dif.addr == FDP_EXTRA)
                       || in_range(dif.addr, FDS_LO, FDS_HI) || (dif.addr == FDS_EXTRA);
        // select 0 takes command and control ports, select 1 only the command block
        dif.hit_pri_hd = in_range(dif.addr, HDP_LO, HDP_HI) || (!dif.pri_sel && dif.addr == HDP_CTL);
        dif.hit_sec_hd = in_range(dif.addr, HDS_LO, HDS_HI) || (!dif.sec_sel && dif.addr == HDS_CTL);
    end
endmodule

/* File: core/pmits_idle_timer.sv */
// pmits_idle_timer: reloadable down-counter that fires once when a nonzero count runs out.
// assumes tick is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ps
module pmits_idle_timer
    import pmits_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       enable,
    input  wire logic       tick,
    input  wire logic       reload,
    input  wire logic [7:0] load_val,
    output logic            expire
);
    pmits_tstate_t state_reg;
    logic [7:0]    cnt_reg;
    logic          expire_reg;
    logic          last_tick;

    assign last_tick = tick && (cnt_reg == 8'h01);

    // count runs only while enabled; enabling starts from the programmed count
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_reg <= PMITS_T_OFF;
            cnt_reg   <= COUNT_RESET;
        end
        else if (!enable)
            state_reg <= PMITS_T_OFF;                       // count is frozen, but re-enabling reloads load_val
        else if (reload || state_reg == PMITS_T_OFF)
        begin
            state_reg <= PMITS_T_RUN;
            cnt_reg   <= load_val;
        end
        else
        begin
            case (state_reg)
                PMITS_T_RUN:
                begin
                    if (last_tick || cnt_reg == 8'h00)
                    begin
                        state_reg <= PMITS_T_EXPIRED;
                        cnt_reg   <= 8'h00;
                    end
                    else if (tick)
                        cnt_reg <= cnt_reg - 8'h01;
                end
                PMITS_T_EXPIRED: cnt_reg <= 8'h00;          // parked until reloaded
                default:         state_reg <= PMITS_T_OFF;
            endcase
        end
    end

    // single pulse on the run-to-expired step taken by the last tick
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            expire_reg <= 1'b0;
        else
            expire_reg <= enable && !reload && state_reg == PMITS_T_RUN && last_tick;
    end

    assign expire = expire_reg;

    a_expire_single: assert property (@(posedge clk_sys) disable iff (srst)
        expire |=> !expire [*3])
        else $error("idle timer expiry repeated");
    a_reload_value: assert property (@(posedge clk_sys) disable iff (srst)
        (enable && reload) |=> (cnt_reg == $past(load_val) && state_reg == PMITS_T_RUN))
        else $error("idle timer not reloaded with programmed count");
endmodule

/* File: core/pmits_pkg.sv */
// pmits_pkg: register map, field positions, legacy port ranges and timing
// constants for the power-management i/o trap and idle-timer block.
// assumes a 20 MHz core clock and 16-bit host i/o addresses.
package pmits_pkg;

    // register offsets on the 8-bit register port
    localparam logic [7:0] REG_PM_ENABLE_ONE   = 8'h80;
    localparam logic [7:0] REG_PM_ENABLE_THREE = 8'h82;
    localparam logic [7:0] REG_PM_ENABLE_FOUR  = 8'h83;
    localparam logic [7:0] REG_STAT_TRAP_VIEW  = 8'h86;
    localparam logic [7:0] REG_STAT_ACPI_VIEW  = 8'h87;
    localparam logic [7:0] REG_RANGE_CFG       = 8'h93;
    localparam logic [7:0] REG_SEC_IDLE_COUNT  = 8'hac;
    localparam logic [7:0] REG_STAT_TRAP_CLR   = 8'hf6;
    localparam logic [7:0] REG_STAT_ACPI_CLR   = 8'hf7;
    localparam logic [7:0] REG_TOP_VIEW        = 8'h00;
    localparam logic [7:0] REG_TOP_CLR         = 8'h02;

    // field positions
    localparam int EN1_PM_BIT      = 0;
    localparam int EN1_TIMERS_BIT  = 1;
    localparam int EN1_TRAPS_BIT   = 2;
    localparam int EN3_PRI_HD_BIT  = 0;
    localparam int EN3_FLOPPY_BIT  = 1;
    localparam int EN3_PARSER_BIT  = 2;
    localparam int EN4_ACPI_BIT    = 5;
    localparam int EN4_SEC_TRAP_BIT = 6;
    localparam int EN4_SEC_IDLE_BIT = 7;
    localparam int CFG_SER_LSB     = 0;
    localparam int CFG_SEC_SEL_BIT = 4;
    localparam int CFG_PRI_SEL_BIT = 5;
    localparam int ST_PRI_HD_BIT   = 0;
    localparam int ST_FLOPPY_BIT   = 1;
    localparam int ST_PARSER_BIT   = 2;
    localparam int ST_SEC_IDLE_BIT = 4;
    localparam int ST_SEC_TRAP_BIT = 5;
    localparam int ST_ACPI_BIT     = 0;
    localparam int TOP_SMI_BIT     = 0;

    // reset values
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET    = 8'h00;
    localparam logic [7:0] COUNT_RESET  = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // serial-port assignment codes that drop a range from the trap
    localparam logic [1:0] SER_DROP_FIRST  = 2'b10;
    localparam logic [1:0] SER_DROP_SECOND = 2'b11;

    // legacy i/o ranges
    localparam logic [15:0] LPT1_LO = 16'h03bc, LPT1_HI = 16'h03be;
    localparam logic [15:0] LPT2_LO = 16'h0378, LPT2_HI = 16'h037f;
    localparam logic [15:0] COM1_LO = 16'h03f8, COM1_HI = 16'h03ff;
    localparam logic [15:0] COM2_LO = 16'h02f8, COM2_HI = 16'h02ff;
    localparam logic [15:0] COM3_LO = 16'h03e8, COM3_HI = 16'h03ef;
    localparam logic [15:0] COM4_LO = 16'h02e8, COM4_HI = 16'h02ef;
    localparam logic [15:0] FDP_LO  = 16'h03f2, FDP_HI  = 16'h03f5, FDP_EXTRA = 16'h03f7;
    localparam logic [15:0] FDS_LO  = 16'h0372, FDS_HI  = 16'h0375, FDS_EXTRA = 16'h0377;
    localparam logic [15:0] HDP_LO  = 16'h01f0, HDP_HI  = 16'h01f7, HDP_CTL   = 16'h03f6;
    localparam logic [15:0] HDS_LO  = 16'h0170, HDS_HI  = 16'h0177, HDS_CTL   = 16'h0376;

    // idle timer timebase
    localparam int CLK_PERIOD_NS    = 50;
    localparam int IDLE_TICK_NS     = 1000000;
    localparam int IDLE_TICK_CYCLES = IDLE_TICK_NS / CLK_PERIOD_NS;

    // idle timer states
    typedef enum logic [1:0] {
        PMITS_T_OFF     = 2'b00,
        PMITS_T_RUN     = 2'b01,
        PMITS_T_EXPIRED = 2'b10
    } pmits_tstate_t;

    // inclusive range compare, used by every decoder range term; single ports compare equal
    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

endpackage

/* File: core/pmits_top.sv */
// pmits_top: power-management i/o traps, secondary disk idle timer and
// acpi timer msb smi source, with second- and top-level status.
// assumes host i/o cycles and the acpi timer msb come from clk_sys logic.
`timescale 1ns/1ps
module pmits_top
    import pmits_pkg::*;
#(
    parameter int TICK_CYCLES = IDLE_TICK_CYCLES
)
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        io_valid,
    input  wire logic [15:0] io_addr,
    input  wire logic        acpi_timer_msb,
    output logic             smi_out
);

    // software-visible control registers
    logic [7:0]  en_one_reg;
    logic [7:0]  en_three_reg;
    logic [7:0]  pm_enable_four_reg;
    logic [7:0]  cfg_reg;
    logic [7:0]  idle_count_reg;

    // status registers and their next values
    logic [7:0]  stat_trap_reg;
    logic [7:0]  stat_trap_next;
    logic        stat_acpi_reg;
    logic        stat_acpi_next;
    logic        top_reg;
    logic        top_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;

    // gating and events
    logic        trap_gate;
    logic        timer_gate;
    logic        acpi_gate;
    logic        ev_parser;
    logic        ev_floppy;
    logic        ev_pri_hd;
    logic        ev_sec_trap;
    logic        ev_sec_idle;
    logic        ev_acpi;
    logic        any_event;
    logic        sec_access;
    logic [7:0]  trap_set;

    // acpi msb history and idle timebase
    logic        msb_prev_reg;
    logic [15:0] tick_cnt_reg;
    logic        tick;

    // read side effects
    logic        rd_clr_trap;
    logic        rd_clr_acpi;
    logic        rd_clr_top;

    pmits_dec_if dif ();

    // decoder sees the live host address and range configuration
    assign dif.addr       = io_addr;
    assign dif.ser_assign = cfg_reg[CFG_SER_LSB +: 2];
    assign dif.pri_sel    = cfg_reg[CFG_PRI_SEL_BIT];
    assign dif.sec_sel    = cfg_reg[CFG_SEC_SEL_BIT];

    pmits_decode u_decode (
        .dif (dif.dec)
    );

    // control register writes; everything starts disabled
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            en_one_reg         <= ENABLE_RESET;
            en_three_reg       <= ENABLE_RESET;
            pm_enable_four_reg <= ENABLE_RESET;
            cfg_reg            <= CFG_RESET;
            idle_count_reg     <= COUNT_RESET;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                REG_PM_ENABLE_ONE:   en_one_reg         <= reg_wdata;
                REG_PM_ENABLE_THREE: en_three_reg       <= reg_wdata;
                REG_PM_ENABLE_FOUR:  pm_enable_four_reg <= reg_wdata;
                REG_RANGE_CFG:       cfg_reg            <= reg_wdata;
                REG_SEC_IDLE_COUNT:  idle_count_reg     <= reg_wdata;
                default:             ;
            endcase
        end
    end

    // nothing works until firmware turns on global power management
    assign trap_gate  = en_one_reg[EN1_PM_BIT] && en_one_reg[EN1_TRAPS_BIT];
    assign timer_gate = en_one_reg[EN1_PM_BIT] && en_one_reg[EN1_TIMERS_BIT]
                        && pm_enable_four_reg[EN4_SEC_IDLE_BIT];
    assign acpi_gate  = en_one_reg[EN1_PM_BIT] && pm_enable_four_reg[EN4_ACPI_BIT];

    // trap events qualify the decoded hit with the cycle and both enables
    assign ev_parser   = io_valid && dif.hit_parser && trap_gate
                         && en_three_reg[EN3_PARSER_BIT];
    assign ev_floppy   = io_valid && dif.hit_floppy && trap_gate
                         && en_three_reg[EN3_FLOPPY_BIT];
    assign ev_pri_hd   = io_valid && dif.hit_pri_hd && trap_gate
                         && en_three_reg[EN3_PRI_HD_BIT];
    assign ev_sec_trap = io_valid && dif.hit_sec_hd && trap_gate
                         && pm_enable_four_reg[EN4_SEC_TRAP_BIT];

    // any access in the secondary ranges restarts the idle count
    assign sec_access = io_valid && dif.hit_sec_hd;

    // free-running timebase for the idle timer, one pulse per period
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            tick_cnt_reg <= 16'h0000;
        else if (tick)
            tick_cnt_reg <= 16'h0000;
        else
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end

    assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

    pmits_idle_timer u_sec_idle (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .enable   (timer_gate),
        .tick     (tick),
        .reload   (sec_access),
        .load_val (idle_count_reg),
        .expire   (ev_sec_idle)
    );

    // msb history; reset loads 0 as the reference before the first sample
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            msb_prev_reg <= 1'b0;
        else
            msb_prev_reg <= acpi_timer_msb;
    end

    // either edge of the msb counts as a toggle
    assign ev_acpi = acpi_gate && (acpi_timer_msb != msb_prev_reg);

    // second-level trap status bits
    always_comb
    begin
        trap_set                  = 8'h00;
        trap_set[ST_PRI_HD_BIT]   = ev_pri_hd;
        trap_set[ST_FLOPPY_BIT]   = ev_floppy;
        trap_set[ST_PARSER_BIT]   = ev_parser;
        trap_set[ST_SEC_IDLE_BIT] = ev_sec_idle;
        trap_set[ST_SEC_TRAP_BIT] = ev_sec_trap;
    end

    assign any_event = (|trap_set) || ev_acpi;

    // reads of the clearing views wipe status; plain views leave it alone
    assign rd_clr_trap = reg_rd && (reg_addr == REG_STAT_TRAP_CLR);
    assign rd_clr_acpi = reg_rd && (reg_addr == REG_STAT_ACPI_CLR);
    assign rd_clr_top  = rd_clr_trap || rd_clr_acpi || (reg_rd && reg_addr == REG_TOP_CLR);

    // a new event in the clearing cycle survives the clear
    always_comb
    begin
        stat_trap_next = (rd_clr_trap ? STATUS_RESET : stat_trap_reg) | trap_set;
        stat_acpi_next = (rd_clr_acpi ? 1'b0 : stat_acpi_reg) | ev_acpi;
        top_next       = (rd_clr_top ? 1'b0 : top_reg) | any_event;
    end

    // status storage
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            stat_trap_reg <= STATUS_RESET;
            stat_acpi_reg <= 1'b0;
            top_reg       <= 1'b0;
        end
        else
        begin
            stat_trap_reg <= stat_trap_next;
            stat_acpi_reg <= stat_acpi_next;
            top_reg       <= top_next;
        end
    end

    // smi is held while the top-level bit stands
    assign smi_out = top_reg;

    // read mux samples status before this cycle's clear takes effect
    always_comb
    begin
        rdata_next = 8'h00;
        case (reg_addr)
            REG_PM_ENABLE_ONE:   rdata_next = en_one_reg;
            REG_PM_ENABLE_THREE: rdata_next = en_three_reg;
            REG_PM_ENABLE_FOUR:  rdata_next = pm_enable_four_reg;
            REG_RANGE_CFG:       rdata_next = cfg_reg;
            REG_SEC_IDLE_COUNT:  rdata_next = idle_count_reg;
            REG_STAT_TRAP_VIEW,
            REG_STAT_TRAP_CLR:   rdata_next = stat_trap_reg;
            REG_STAT_ACPI_VIEW,
            REG_STAT_ACPI_CLR:   rdata_next[ST_ACPI_BIT] = stat_acpi_reg;
            REG_TOP_VIEW,
            REG_TOP_CLR:         rdata_next[TOP_SMI_BIT] = top_reg;
            default:             rdata_next = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            rdata_reg <= 8'h00;
        else if (reg_rd)
            rdata_reg <= rdata_next;
        else
            rdata_reg <= 8'h00;
    end

    assign reg_rdata = rdata_reg;

    // checks on the trap, timer and acpi paths

    a_parser_status: assert property (@(posedge clk_sys) disable iff (srst)
        (io_valid && dif.hit_parser && trap_gate && en_three_reg[EN3_PARSER_BIT])
        |=> (stat_trap_reg[ST_PARSER_BIT] && smi_out))
        else $error("parallel/serial trap did not set its status");

    a_floppy_status: assert property (@(posedge clk_sys) disable iff (srst)
        (io_valid && dif.hit_floppy && trap_gate && en_three_reg[EN3_FLOPPY_BIT])
        |=> stat_trap_reg[ST_FLOPPY_BIT])
        else $error("floppy trap did not set its status");

    a_pri_hd_status: assert property (@(posedge clk_sys) disable iff (srst)
        (io_valid && dif.hit_pri_hd && trap_gate && en_three_reg[EN3_PRI_HD_BIT])
        |=> stat_trap_reg[ST_PRI_HD_BIT])
        else $error("primary disk trap did not set its status");

    a_sec_trap_now: assert property (@(posedge clk_sys) disable iff (srst)
        (io_valid && dif.hit_sec_hd && trap_gate && pm_enable_four_reg[EN4_SEC_TRAP_BIT])
        |=> (stat_trap_reg[ST_SEC_TRAP_BIT] && smi_out))
        else $error("secondary disk trap did not raise smi next cycle");

    a_idle_expiry: assert property (@(posedge clk_sys) disable iff (srst)
        ev_sec_idle |=> (stat_trap_reg[ST_SEC_IDLE_BIT] && smi_out))
        else $error("idle expiry did not set status and smi");

    a_trap_gated: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(stat_trap_reg[ST_PARSER_BIT]) |-> $past(trap_gate))
        else $error("trap status set with global trap enable off");

    a_acpi_toggle: assert property (@(posedge clk_sys) disable iff (srst)
        (acpi_gate && $changed(acpi_timer_msb) && !$past(srst))
        |=> (stat_acpi_reg && smi_out))
        else $error("acpi msb toggle did not raise smi");

    a_set_beats_clear: assert property (@(posedge clk_sys) disable iff (srst)
        (rd_clr_top && any_event) |=> smi_out)
        else $error("event lost under a status clear");

    a_reset_disabled: assert property (@(posedge clk_sys) disable iff (srst)
        $fell(srst) |-> (en_one_reg == 8'h00 && pm_enable_four_reg == 8'h00 && !smi_out))
        else $error("enables not cleared by reset");

    // decoder cross-checks built from the raw range constants, so a decode slip shows up here, then enable gating of the status bits
    a_com1_dropped: assert property (@(posedge clk_sys) disable iff (srst)
        (in_range(io_addr, COM1_LO, COM1_HI) && cfg_reg[CFG_SER_LSB +: 2] == SER_DROP_FIRST) |-> !dif.hit_parser)
        else $error("first serial range hit while assigned away");

    a_com2_dropped: assert property (@(posedge clk_sys) disable iff (srst)
        (in_range(io_addr, COM2_LO, COM2_HI) && cfg_reg[CFG_SER_LSB +: 2] == SER_DROP_SECOND) |-> !dif.hit_parser)
        else $error("second serial range hit while assigned away");

    a_printer_hit: assert property (@(posedge clk_sys) disable iff (srst)
        (io_valid && (in_range(io_addr, LPT1_LO, LPT1_HI) || in_range(io_addr, LPT2_LO, LPT2_HI))
         && trap_gate && en_three_reg[EN3_PARSER_BIT]) |=> (stat_trap_reg[ST_PARSER_BIT] && smi_out))
        else $error("printer port access not trapped");

    a_serial_hit: assert property (@(posedge clk_sys) disable iff (srst)
        (io_valid && (in_range(io_addr, COM3_LO, COM3_HI) || in_range(io_addr, COM4_LO, COM4_HI))
         && trap_gate && en_three_reg[EN3_PARSER_BIT]) |=> (stat_trap_reg[ST_PARSER_BIT] && smi_out))
        else $error("third or fourth serial access not trapped");

    a_floppy_hit: assert property (@(posedge clk_sys) disable iff (srst)
        (io_valid && (in_range(io_addr, FDP_LO, FDP_HI) || io_addr == FDP_EXTRA
         || in_range(io_addr, FDS_LO, FDS_HI) || io_addr == FDS_EXTRA)
         && trap_gate && en_three_reg[EN3_FLOPPY_BIT]) |=> (stat_trap_reg[ST_FLOPPY_BIT] && smi_out))
        else $error("floppy port access not trapped");

    a_pri_hd_hit: assert property (@(posedge clk_sys) disable iff (srst)
        (io_valid && in_range(io_addr, HDP_LO, HDP_HI) && trap_gate && en_three_reg[EN3_PRI_HD_BIT])
        |=> (stat_trap_reg[ST_PRI_HD_BIT] && smi_out))
        else $error("primary disk command access not trapped");

    a_sec_hd_hit: assert property (@(posedge clk_sys) disable iff (srst)
        (io_valid && in_range(io_addr, HDS_LO, HDS_HI) && trap_gate && pm_enable_four_reg[EN4_SEC_TRAP_BIT])
        |=> (stat_trap_reg[ST_SEC_TRAP_BIT] && smi_out))
        else $error("secondary disk command access not trapped");

    a_floppy_gated: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(stat_trap_reg[ST_FLOPPY_BIT]) |-> $past(trap_gate))
        else $error("floppy status set with global trap enable off");

    a_pri_hd_gated: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(stat_trap_reg[ST_PRI_HD_BIT]) |-> $past(trap_gate))
        else $error("primary disk status set with global trap enable off");

    a_acpi_gated: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(stat_acpi_reg) |-> $past(acpi_gate))
        else $error("acpi status set with its enable off");

    // reset must leave every enable off on the very next edge
    a_enable_reset: assert property (@(posedge clk_sys)
        srst |=> (en_one_reg == ENABLE_RESET && en_three_reg == ENABLE_RESET && pm_enable_four_reg == ENABLE_RESET))
        else $error("enables not off after reset");

endmodule

/* File: test/pmits_host.sv */
// pmits_host: host i/o cycle source standing in front of the trap block.
// assumes clk_sys shared with the block; one access per io_cycle call.
`timescale 1ns/1ps
module pmits_host
(
    input  wire logic        clk_sys,
    output logic             io_valid,
    output logic      [15:0] io_addr
);
    initial
    begin
        io_valid = 1'b0;
        io_addr  = 16'hffff;
    end

    // one-cycle access; address inverted afterwards so a stale value never decodes
    task automatic io_cycle(input logic [15:0] a);
        @(posedge clk_sys);
        io_valid <= 1'b1;
        io_addr  <= a;
        @(posedge clk_sys);
        io_valid <= 1'b0;
        io_addr  <= ~a;
    endtask
endmodule

/* File: test/tb_pmits_top.sv */
// tb_pmits_top: self-checking bench for the i/o trap and idle timer block.
// assumes TICK_CYCLES of 4 so idle expiry lands within tens of cycles.
`timescale 1ns/1ps
module tb_pmits_top;
    logic        clk_sys, srst, reg_wr, reg_rd, acpi_timer_msb, smi_out, io_valid;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, e;
    logic [15:0] io_addr;
    logic [31:0] rs;
    int          err_count, n_tests, i, k;
    logic [15:0] corner [12] = '{16'h03bc, 16'h03be, 16'h03bf, 16'h0378, 16'h03f8, 16'h02ff,
                                 16'h03ef, 16'h02e8, 16'h03f7, 16'h03f6, 16'h0376, 16'h0170};
    logic [7:0]  cfgs [4] = '{8'h00, 8'h02, 8'h03, 8'h30};

    pmits_top #(.TICK_CYCLES(4)) pmits_top_i (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .io_valid(io_valid), .io_addr(io_addr), .acpi_timer_msb(acpi_timer_msb), .smi_out(smi_out));
    pmits_host pmits_host_i (.clk_sys(clk_sys), .io_valid(io_valid), .io_addr(io_addr));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic inr(input logic [15:0] a, lo, hi);
        return (a >= lo) && (a <= hi);
    endfunction
    // expected trap status view for one access with all traps on
    function automatic logic [7:0] exp_st(input logic [15:0] a, input logic [7:0] c);
        logic [7:0] s;
        s = 8'h00;
        s[2] = inr(a, 16'h03bc, 16'h03be) | inr(a, 16'h0378, 16'h037f) | inr(a, 16'h03e8, 16'h03ef)
             | inr(a, 16'h02e8, 16'h02ef) | (inr(a, 16'h03f8, 16'h03ff) && c[1:0] != 2'b10)
             | (inr(a, 16'h02f8, 16'h02ff) && c[1:0] != 2'b11);
        s[1] = inr(a, 16'h03f2, 16'h03f5) | (a == 16'h03f7) | inr(a, 16'h0372, 16'h0375) | (a == 16'h0377);
        s[0] = inr(a, 16'h01f0, 16'h01f7) | (a == 16'h03f6 && !c[5]);
        s[5] = inr(a, 16'h0170, 16'h0177) | (a == 16'h0376 && !c[4]);
        return s;
    endfunction

    task automatic chk(input string nm, input logic [7:0] ex, got);
        n_tests++;
        if (got !== ex)
        begin
            $display("wrong value %s expected %h seen %h", nm, ex, got);
            err_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // one access, then smi level and the clearing status read
    task automatic trap(input logic [15:0] a, input logic [7:0] c);
        wr(8'h93, c);
        pmits_host_i.io_cycle(a);
        repeat (2) @(posedge clk_sys);
        e = exp_st(a, c);
        chk("smi_out", {7'h00, |e}, {7'h00, smi_out});
        rd(8'hf6, d);
        chk("trap status", e, d);
    endtask
    task automatic wait_smi();
        for (i = 0; i < 60 && smi_out !== 1'b1; i++) @(posedge clk_sys);
        chk("idle smi", 8'h01, {7'h00, smi_out});
        rd(8'h86, d);
        chk("idle view", 8'h10, d);
        rd(8'hf6, d);
        chk("idle status", 8'h10, d);
    endtask
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // watchdog, far beyond the expected few thousand cycles
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        err_count++;
        end_sim();
    end

    initial
    begin
        {srst, reg_wr, reg_rd, acpi_timer_msb, reg_addr, reg_wdata} = {1'b1, 19'h0};
        err_count = 0;
        n_tests   = 0;
        rs        = 32'd79;
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        // enables come up off; unmapped place reads zero
        foreach (cfgs[j])
        begin
            rd(j == 0 ? 8'h80 : j == 1 ? 8'h82 : j == 2 ? 8'h83 : 8'h55, d);
            chk("reset value", 8'h00, d);
        end
        // traps without the global trap bit stay silent
        wr(8'h80, 8'h01);
        wr(8'h82, 8'h07);
        pmits_host_i.io_cycle(16'h0378);
        repeat (2) @(posedge clk_sys);
        rd(8'hf6, d);
        chk("gated status", 8'h00, d);
        // every trap source with corners over serial and disk selects
        wr(8'h80, 8'h05);
        wr(8'h83, 8'h40);
        foreach (cfgs[c]) foreach (corner[j]) trap(corner[j], cfgs[c]);
        for (k = 0; k < 200; k++)
        begin
            rs = xs(rs);
            trap({6'h00, rs[9:0]}, {2'b00, rs[17:16], 2'b00, rs[19:18]});
        end
        // idle timer expiry, hold at zero, reload by a secondary access
        wr(8'h80, 8'h03);
        wr(8'hac, 8'h02);
        rd(8'hac, d);
        chk("idle count", 8'h02, d);
        wr(8'h83, 8'h80);
        wait_smi();
        repeat (40) @(posedge clk_sys);
        chk("held idle", 8'h00, {7'h00, smi_out});
        pmits_host_i.io_cycle(16'h0172);
        wait_smi();
        // acpi msb toggles both ways
        wr(8'h80, 8'h01);
        wr(8'h83, 8'h20);
        repeat (2)
        begin
            @(posedge clk_sys);
            acpi_timer_msb <= ~acpi_timer_msb;
            repeat (2) @(posedge clk_sys);
            chk("acpi smi", 8'h01, {7'h00, smi_out});
            rd(8'h00, d);
            chk("top view", 8'h01, d);
            rd(8'h02, d);
            chk("top clear", 8'h01, d);
            chk("smi after clear", 8'h00, {7'h00, smi_out});
            rd(8'hf7, d);
            chk("acpi status", 8'h01, d);
        end
        end_sim();
    end
endmodule
